// [verilog/jtcs_port.sv]
// Purpose: two-die test chain, reset path and programming status pins
// Assumes: test pins are asynchronous to ref_clk and slower than ref_clk/4
// Notes: results pass a two-entry buffer so a busy status pin stall loses none
module jtcs_port
    import jtcs_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst,
    // test pins
    input  wire logic                  tck,
    input  wire logic                  tms,
    input  wire logic                  tdi,
    output logic                       tdo,
    // package reset and memory die reset
    input  wire logic                  reset_in,
    output logic                       mem_die_rst,
    // six-pin option
    input  wire logic                  six_pin_en,
    output logic                       prog_status_flag,
    output logic                       prog_status_flag_oe,
    output logic                       prog_error_flag,
    output logic                       prog_error_flag_oe,
    // flash engine of the memory die
    input  wire jtcs_pkg::jtcs_result_s flash_result,
    input  wire logic                  flash_result_valid,
    output logic                       flash_result_ready,
    output logic                       flash_busy_start,
    output logic                       in_system_programming
);
    import jtcs_pkg::*;

    logic [1:0] tck_s_q, tms_s_q, tdi_s_q, rin_s_q, six_s_q;
    logic       tck_d1_q;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            tck_s_q  <= 2'h0;
            tms_s_q  <= 2'h0;
            tdi_s_q  <= 2'h0;
            rin_s_q  <= 2'h0;
            six_s_q  <= 2'h0;
            tck_d1_q <= 1'b0;
        end
        else
        begin
            tck_s_q  <= {tck_s_q[0], tck};
            tms_s_q  <= {tms_s_q[0], tms};
            tdi_s_q  <= {tdi_s_q[0], tdi};
            rin_s_q  <= {rin_s_q[0], reset_in};
            six_s_q  <= {six_s_q[0], six_pin_en};
            tck_d1_q <= tck_s_q[1];
        end

    wire tck_rise = tck_s_q[1] & ~tck_d1_q;
    wire tck_fall = ~tck_s_q[1] & tck_d1_q;
    wire tms_s    = tms_s_q[1];
    wire tdi_s    = tdi_s_q[1];
    // package reset reaches the processor die only, which forwards it
    assign mem_die_rst = rin_s_q[1];

    logic [1:0]  ser_in, ser_out;
    logic [IR_W-1:0] ir_v [2];
    assign ser_in[0] = tdi_s;
    assign ser_in[1] = ser_out[0];

    // one tap per die; taps reset only on the module rst, never on the package reset_in
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_tap
            jtcs_state_e st_q, st_d;
            logic [IR_W-1:0] irs_q, ir_q;
            logic byp_q, out_q;
            always_comb
            begin
                unique case (st_q)
                    JTCS_RESET: st_d = tms_s ? JTCS_RESET : JTCS_IDLE;
                    JTCS_IDLE:  st_d = tms_s ? JTCS_SELDR : JTCS_IDLE;
                    JTCS_SELDR: st_d = tms_s ? JTCS_SELIR : JTCS_CAPDR;
                    JTCS_CAPDR: st_d = tms_s ? JTCS_EX1DR : JTCS_SHDR;
                    JTCS_SHDR:  st_d = tms_s ? JTCS_EX1DR : JTCS_SHDR;
                    JTCS_EX1DR: st_d = tms_s ? JTCS_UPDR  : JTCS_PSDR;
                    JTCS_PSDR:  st_d = tms_s ? JTCS_EX2DR : JTCS_PSDR;
                    JTCS_EX2DR: st_d = tms_s ? JTCS_UPDR  : JTCS_SHDR;
                    JTCS_UPDR:  st_d = tms_s ? JTCS_SELDR : JTCS_IDLE;
                    JTCS_SELIR: st_d = tms_s ? JTCS_RESET : JTCS_CAPIR;
                    JTCS_CAPIR: st_d = tms_s ? JTCS_EX1IR : JTCS_SHIR;
                    JTCS_SHIR:  st_d = tms_s ? JTCS_EX1IR : JTCS_SHIR;
                    JTCS_EX1IR: st_d = tms_s ? JTCS_UPIR  : JTCS_PSIR;
                    JTCS_PSIR:  st_d = tms_s ? JTCS_EX2IR : JTCS_PSIR;
                    JTCS_EX2IR: st_d = tms_s ? JTCS_UPIR  : JTCS_SHIR;
                    JTCS_UPIR:  st_d = tms_s ? JTCS_SELDR : JTCS_IDLE;
                    default:    st_d = JTCS_RESET;
                endcase
            end
            always_ff @(posedge ref_clk or posedge rst)
                if (rst)
                begin
                    st_q  <= JTCS_RESET;
                    irs_q <= IR_BYPASS;
                    ir_q  <= IR_BYPASS;
                    byp_q <= 1'b0;
                    out_q <= 1'b0;
                end
                else if (tck_rise)
                begin
                    st_q <= st_d;
                    if (st_q == JTCS_CAPIR)
                        irs_q <= IR_CAPTURE;
                    else if (st_q == JTCS_SHIR)
                        irs_q <= {ser_in[g], irs_q[IR_W-1:1]};
                    if (st_q == JTCS_UPIR)
                        ir_q <= irs_q;
                    else if (st_q == JTCS_RESET)
                        ir_q <= IR_BYPASS;
                    if (st_q == JTCS_CAPDR)
                        byp_q <= 1'b0;
                    else if (st_q == JTCS_SHDR)
                        byp_q <= ser_in[g];
                end
                else if (tck_fall)
                    out_q <= (st_q == JTCS_SHIR) ? irs_q[0] : byp_q;
            assign ser_out[g] = out_q;
            assign ir_v[g]    = ir_q;
        end
    endgenerate

    assign tdo = ser_out[1];

    // programming mode is entered and left purely from the chain
    logic prog_q;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
            prog_q <= 1'b0;
        else if (ir_v[0] == IR_PROG_IN)
            prog_q <= 1'b1;
        else if (ir_v[0] == IR_PROG_OUT)
            prog_q <= 1'b0;
    // both flash and logic arrays are programmable in this mode
    assign in_system_programming = prog_q;

    // two-entry result buffer; status pin drains one entry per update
    jtcs_result_s mem_q [2];
    logic [1:0] cnt_q;
    logic       rp_q, wp_q, ok_q, rdy_q;
    wire full    = (cnt_q == FIFO_DEPTH);
    wire push    = flash_result_valid & ~full;
    wire pop     = (cnt_q != 2'h0) & prog_q;
    assign flash_result_ready = ~full;
    assign flash_busy_start   = prog_q & (cnt_q == 2'h0) & ~flash_result_valid;
    // payload needs no reset; pointers and count are cleared and both flags are set high
    always_ff @(posedge ref_clk)
        if (push)
            mem_q[wp_q] <= flash_result;
    always_ff @(posedge ref_clk or posedge rst)
        if (rst)
        begin
            cnt_q <= 2'h0;
            rp_q  <= 1'b0;
            wp_q  <= 1'b0;
            rdy_q <= 1'b1;
            ok_q  <= 1'b1;
        end
        else
        begin
            if (push)
                wp_q <= ~wp_q;
            if (pop)
            begin
                rdy_q <= mem_q[rp_q].done;
                ok_q  <= ~mem_q[rp_q].error;
                rp_q  <= ~rp_q;
            end
            else if (~prog_q)
            begin
                rdy_q <= 1'b1;
                ok_q  <= 1'b1;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end

    // one enable for both pins, and only during programming
    wire pins_on = six_s_q[1] & prog_q;
    assign prog_status_flag    = rdy_q;
    assign prog_error_flag     = ok_q;
    assign prog_status_flag_oe = pins_on;
    assign prog_error_flag_oe  = pins_on;

    a_pins_paired: assert property (@(posedge ref_clk) disable iff (rst)
        prog_status_flag_oe == prog_error_flag_oe)
        else $error("status and error enables differ");
    a_pins_prog_only: assert property (@(posedge ref_clk) disable iff (rst)
        prog_status_flag_oe |-> in_system_programming)
        else $error("status pins driven outside programming");
    a_chain_order: assert property (@(posedge ref_clk) disable iff (rst)
        (tck_fall && g_tap[1].st_q == JTCS_SHDR) |=> tdo == $past(g_tap[1].byp_q))
        else $error("serial output not from processor die");
    a_chain_link: assert property (@(posedge ref_clk) disable iff (rst)
        (tck_rise && g_tap[1].st_q == JTCS_SHDR) |=> g_tap[1].byp_q == $past(g_tap[0].out_q))
        else $error("processor die not fed by memory die");
    a_reset_path: assert property (@(posedge ref_clk) disable iff (rst)
        (!$past(rst) && !$past(rst, 2)) |-> mem_die_rst == $past(reset_in, 2))
        else $error("memory die reset not forwarded");
    a_tap_stable: assert property (@(posedge ref_clk) disable iff (rst)
        !tck_rise |=> $stable(g_tap[0].st_q))
        else $error("tap moved without test clock edge");
    a_tap_shared: assert property (@(posedge ref_clk) disable iff (rst)
        g_tap[0].st_q == g_tap[1].st_q)
        else $error("tap states diverged");
    a_tap_reset5: assert property (@(posedge ref_clk) disable iff (rst)
        (tck_rise && tms_s && g_tap[0].st_q == JTCS_SELIR) |=> g_tap[0].st_q == JTCS_RESET)
        else $error("tap did not reach reset");
    a_status_idle: assert property (@(posedge ref_clk) disable iff (rst)
        (!prog_q && !$past(prog_q)) |-> prog_status_flag && prog_error_flag)
        else $error("status flags not idle");
    c_prog_enter: cover property (@(posedge ref_clk) disable iff (rst) $rose(prog_q));
    c_err_seen: cover property (@(posedge ref_clk) disable iff (rst) $fell(prog_error_flag));
    c_fifo_full: cover property (@(posedge ref_clk) disable iff (rst) full);
    c_refused: cover property (@(posedge ref_clk) disable iff (rst)
        flash_result_valid && !flash_result_ready);
    c_busy_seen: cover property (@(posedge ref_clk) disable iff (rst) flash_busy_start);
endmodule : jtcs_port

// [verilog/jtcs_pkg.sv]
// Purpose: constants and types for the two-die test and programming port
// Assumes: link pins sampled on ref_clk at 100 MHz
// Notes: none
package jtcs_pkg;
    localparam int unsigned IR_W = 4;
    localparam logic [IR_W-1:0] IR_BYPASS   = 4'hf;
    localparam logic [IR_W-1:0] IR_PROG_IN  = 4'h1;
    localparam logic [IR_W-1:0] IR_PROG_OUT = 4'h2;
    localparam logic [IR_W-1:0] IR_CAPTURE  = 4'h1;
    localparam logic [1:0]      FIFO_DEPTH  = 2'h2;

    typedef enum logic [15:0] {
        JTCS_RESET = 16'h0001, JTCS_IDLE  = 16'h0002, JTCS_SELDR = 16'h0004,
        JTCS_CAPDR = 16'h0008, JTCS_SHDR  = 16'h0010, JTCS_EX1DR = 16'h0020,
        JTCS_PSDR  = 16'h0040, JTCS_EX2DR = 16'h0080, JTCS_UPDR  = 16'h0100,
        JTCS_SELIR = 16'h0200, JTCS_CAPIR = 16'h0400, JTCS_SHIR  = 16'h0800,
        JTCS_EX1IR = 16'h1000, JTCS_PSIR  = 16'h2000, JTCS_EX2IR = 16'h4000,
        JTCS_UPIR  = 16'h8000
    } jtcs_state_e;

    // one programming outcome from the flash engine
    typedef struct packed {
        logic done;
        logic error;
    } jtcs_result_s;
endpackage : jtcs_pkg

// [test/jtcs_equip.sv]
// Purpose: behavioural external test and programming equipment
// Assumes: 160 ns test clock built from ref_clk falling edges
// Notes: tck stands low between scans; tdi toggles once a scan ends
module jtcs_equip (
    // clock and serial return
    input  wire logic ref_clk,
    input  wire logic tdo,
    // driven pins
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      reset_in
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        repeat (8) @(negedge ref_clk);
        o = tdo;
        tck = 1'b1;
        repeat (8) @(negedge ref_clk);
        tck = 1'b0;
    endtask : step
    // idle to idle; other die's code sent first so it sits in bypass
    task automatic scan(input logic ir, input logic [15:0] v, input int n,
                        output logic [15:0] o);
        logic b;
        o = 16'h0000;
        step(1'b1, 1'b0, b);
        if (ir)
        begin
            step(1'b1, 1'b0, b);
        end
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, v[i], o[i]);
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        tdi = ~tdi;
    endtask : scan
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        reset_in = 1'b0;
    end
endmodule : jtcs_equip

// [test/jtcs_port_tb.sv]
// Purpose: self-checking bench for the two-die test port
// Assumes: flags pop one result per cycle while programming
// Notes: flag results checked from a queue of notes
module jtcs_port_tb;
    import jtcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, rst, tck, tms, tdi, tdo, reset_in, mem_die_rst, six_pin_en;
    logic prog_status_flag, prog_status_flag_oe, prog_error_flag, prog_error_flag_oe;
    logic flash_result_valid, flash_result_ready, flash_busy_start, in_system_programming;
    jtcs_result_s flash_result, e;
    jtcs_result_s exp_q[$];
    int           fail_count, tests_run, cyc, seed;
    logic [15:0]  so, v;
    logic [1:0]   acc;
    logic         b;
    jtcs_port dut (.ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .reset_in(reset_in), .mem_die_rst(mem_die_rst), .six_pin_en(six_pin_en),
        .prog_status_flag(prog_status_flag), .prog_status_flag_oe(prog_status_flag_oe),
        .prog_error_flag(prog_error_flag), .prog_error_flag_oe(prog_error_flag_oe),
        .flash_result(flash_result), .flash_result_valid(flash_result_valid),
        .flash_result_ready(flash_result_ready), .flash_busy_start(flash_busy_start),
        .in_system_programming(in_system_programming));
    jtcs_equip eq (.ref_clk(ref_clk), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi),
        .reset_in(reset_in));
    task automatic chk(input string n, input logic [15:0] ex, input logic [15:0] g);
        tests_run++;
        if (g !== ex)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, ex, g);
        end
    endtask : chk
    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // flags land one cycle after the edge that takes a result
    always @(posedge ref_clk) acc <= {acc[0], flash_result_valid & flash_result_ready};
    always @(negedge ref_clk)
    begin
        if (acc[1] === 1'b1 && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            chk("status", e.done, prog_status_flag);
            chk("error", !e.error, prog_error_flag);
        end
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc > 6000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    initial
    begin
        {rst, six_pin_en, flash_result, flash_result_valid, acc} = 7'h40;
        seed = 31324;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        chk("reset", 6'h28, {prog_status_flag, prog_status_flag_oe, prog_error_flag,
            prog_error_flag_oe, in_system_programming, tdo});
        eq.reset_in = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("mem_die_rst", 1'b1, mem_die_rst);
        eq.step(1'b0, 1'b0, b);
        v = $random(seed);
        eq.scan(1'b0, v, 16, so);
        chk("bypass", {v[13:0], 2'b00}, so);
        eq.scan(1'b1, 16'h001f, 8, so);
        chk("prog_oe", 3'h4, {in_system_programming, prog_status_flag_oe,
            prog_error_flag_oe});
        six_pin_en = 1'b1;
        repeat (3) @(negedge ref_clk);
        chk("oe", 2'h3, {prog_status_flag_oe, prog_error_flag_oe});
        for (int i = 0; i < 8; i++)
        begin
            v = $random(seed);
            flash_result = v[1:0];
            flash_result_valid = 1'b1;
            if (flash_result_ready === 1'b1)
                exp_q.push_back(flash_result);
            @(negedge ref_clk);
        end
        flash_result_valid = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("drained", 0, exp_q.size());
        chk("busy", 1'b1, flash_busy_start);
        eq.scan(1'b1, 16'h002f, 8, so);
        chk("prog_exit", 5'h0a, {in_system_programming, prog_status_flag,
            prog_status_flag_oe, prog_error_flag, prog_error_flag_oe});
        // outside programming nothing drains: two results fill the buffer
        for (int i = 0; i < 3; i++)
        begin
            flash_result = 2'h1;
            flash_result_valid = 1'b1;
            chk("ready", i < 2, flash_result_ready);
            @(negedge ref_clk);
        end
        flash_result_valid = 1'b0;
        chk("idle_flags", 2'h3, {prog_status_flag, prog_error_flag});
        eq.reset_in = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("mem_die_rst", 1'b0, mem_die_rst);
        wrap_up();
    end
endmodule : jtcs_port_tb
